// ### hdl/adcri_top.sv
// converter register interface: control, channel select, status, result and busy timing
//
// Overview of operation
// - status register holds only the result-ready flag, at bit 0.
// - each finished conversion sets result-ready and, when the interrupt mask bit is set, raises the converter interrupt.
// - reading the result register clears result-ready automatically.
// - busy output is high throughout a conversion, low once it finishes.
// - busy reaches port bit two only when its port function is selected.
// - result register keeps the 12-bit value of the latest conversion.
// - accessing the soft reset register restores every converter register to default.
// - control register sets enable, operating mode and conversion trigger source.
// - temperature sensor is an extra selectable channel of the input multiplexer.
// - gain register sets amplifier gain for the two gain channels.
// - separate registers select positive and negative input channels.
// - single software conversion returns trigger field to pin trigger when done.
// - result sits in bits 16..27, top four bits filled with sign.
module adcri_top #(
  parameter int unsigned RES_WIDTH = adcri_pkg::RES_W
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       clk_en_i,
  input  wire adcri_pkg::adcri_bus_req_t  bus_req_i,
  output logic [31:0]                     rdata_o,
  input  wire logic                       conv_pin_i,
  input  wire logic                       timer0_i,
  input  wire logic                       timer1_i,
  input  wire logic                       logic_trig_i,
  input  wire logic [RES_WIDTH-1:0]       analog_code_i,
  output adcri_pkg::adcri_conv_req_t      conv_req_o,
  output logic                            busy_o,
  output logic                            port0_bit_two_o,
  output logic                            irq_o
);

  typedef enum logic [1:0] {
    ADCRI_IDLE    = 2'b01,
    ADCRI_CONVERT = 2'b10
  } adcri_state_t;

  adcri_state_t state;
  logic [15:0]  converter_control_reg;
  logic [4:0]   positive_channel_select;
  logic [4:0]   negative_channel_select;
  logic [4:0]   amplifier_gain_setting;
  logic [31:0]  port0_function_config;
  logic [0:0]   irq_mask;
  logic         result_ready_flag;
  logic [11:0]  conversion_result;
  logic [15:0]  clk_count;
  logic [15:0]  conv_len;
  logic         conv_done;
  logic         start;
  logic         trig_pulse;
  logic [3:0]   ext_sync1;
  logic [3:0]   ext_sync2;
  logic [3:0]   ext_prev;
  logic [RES_WIDTH-1:0] code_sync1;
  logic [RES_WIDTH-1:0] code_sync2;
  logic         soft_rst;
  logic         wr_ok;
  logic         rd_result;
  logic         wr_status_clr;
  logic         next_ready;
  logic         next_busy;
  logic [15:0]  conv_len_q;

  // power of two from a three bit exponent code
  function automatic logic [15:0] pow2(input logic [2:0] code);
    pow2 = 16'h0001 << code;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  adcri_pkg::adcri_trig_t trig_sel;
  logic [2:0] acq_code;
  logic [2:0] div_code;
  logic       temp_chan;

  assign trig_sel  = adcri_pkg::adcri_trig_t'(
                     converter_control_reg[adcri_pkg::CTL_TYPE_LSB +: 3]);
  assign temp_chan = (positive_channel_select == adcri_pkg::CHAN_TEMP);
  // temperature channel forces slow timing, user timing returns afterwards
  assign acq_code  = temp_chan ? adcri_pkg::TEMP_ACQ_CODE
                               : converter_control_reg[adcri_pkg::CTL_ACQ_LSB +: 3];
  assign div_code  = temp_chan ? adcri_pkg::TEMP_DIV_CODE
                               : converter_control_reg[adcri_pkg::CTL_DIV_LSB +: 3];
  // acquisition code n means 2^(n+1) converter clocks; divider code n means 2^n core clocks
  assign conv_len  = 16'((16'(adcri_pkg::EXTRA_CLOCKS) + (pow2(acq_code) << 1))
                         << div_code);

  // length is frozen at start, so a control or channel write mid-conversion
  // cannot move the end point below the running count and strand the sequencer
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      conv_len_q <= 16'h0000;
    end else if (clk_en_i && start) begin
      conv_len_q <= conv_len;
    end
  end

  // a read of the soft reset address resets too, so polling it is destructive
  assign wr_ok     = clk_en_i && bus_req_i.wr;
  assign soft_rst  = clk_en_i && (bus_req_i.wr || bus_req_i.rd) &&
                     hit(bus_req_i.addr, adcri_pkg::OFF_SOFT_RST);
  assign rd_result = clk_en_i && bus_req_i.rd && hit(bus_req_i.addr, adcri_pkg::OFF_RESULT);
  assign wr_status_clr = wr_ok && hit(bus_req_i.addr, adcri_pkg::OFF_STATUS) &&
                         bus_req_i.wdata[adcri_pkg::READY_BIT];

  // pin-side trigger inputs pass two flops before edge detection
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ext_sync1 <= 4'h0;
      ext_sync2 <= 4'h0;
      ext_prev  <= 4'h0;
    end else if (clk_en_i) begin
      ext_sync1 <= {logic_trig_i, timer1_i, timer0_i, conv_pin_i};
      ext_sync2 <= ext_sync1;
      ext_prev  <= ext_sync2;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      code_sync1 <= '0;
      code_sync2 <= '0;
    end else if (clk_en_i) begin
      code_sync1 <= analog_code_i;
      code_sync2 <= code_sync1;
    end
  end

  logic [3:0] ext_rise;
  assign ext_rise = ext_sync2 & ~ext_prev;

  // trigger source decode
  always_comb begin
    unique case (trig_sel)
      adcri_pkg::ADCRI_TRIG_PIN:    trig_pulse = ext_rise[0];
      adcri_pkg::ADCRI_TRIG_TIMER0: trig_pulse = ext_rise[1];
      adcri_pkg::ADCRI_TRIG_TIMER1: trig_pulse = ext_rise[2];
      adcri_pkg::ADCRI_TRIG_LOGIC:  trig_pulse = ext_rise[3];
      adcri_pkg::ADCRI_TRIG_SINGLE: trig_pulse = 1'b1;
      adcri_pkg::ADCRI_TRIG_CONT:   trig_pulse = 1'b1;
      default:                      trig_pulse = 1'b0;
    endcase
  end

  // a pin held high past the end of a conversion restarts it
  logic pin_level_hold;
  assign pin_level_hold = (trig_sel == adcri_pkg::ADCRI_TRIG_PIN) && ext_sync2[0];

  assign start = (state == ADCRI_IDLE) &&
                 converter_control_reg[adcri_pkg::CTL_EN_BIT] &&
                 converter_control_reg[adcri_pkg::CTL_PWR_BIT] &&
                 !soft_rst &&
                 (trig_pulse || pin_level_hold);
  // conv_done marks the last converter clock; flag, result and busy settle on its edge
  assign conv_done = (state == ADCRI_CONVERT) && (clk_count == conv_len_q - 16'h0001);
  // busy rises with the sample request, so it covers every clock of the conversion
  assign next_busy = start || ((state == ADCRI_CONVERT) && !conv_done && !soft_rst);

  // conversion sequencer
  // continuous mode passes through idle for one clock, so busy dips between results
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state     <= ADCRI_IDLE;
      clk_count <= 16'h0000;
    end else if (clk_en_i) begin
      if (soft_rst) begin
        state     <= ADCRI_IDLE;
        clk_count <= 16'h0000;
      end else begin
        unique case (state)
          ADCRI_IDLE: begin
            clk_count <= 16'h0000;
            if (start) begin
              state <= ADCRI_CONVERT;
            end
          end
          ADCRI_CONVERT: begin
            clk_count <= clk_count + 16'h0001;
            if (conv_done) begin
              state <= ADCRI_IDLE;
            end
          end
          default: begin
            state <= ADCRI_IDLE;
          end
        endcase
      end
    end
  end

  // busy and its port copy are registered from the next busy value
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      busy_o          <= 1'b0;
      port0_bit_two_o <= 1'b0;
    end else if (clk_en_i) begin
      busy_o          <= next_busy;
      port0_bit_two_o <= port0_function_config[adcri_pkg::PORT_BUSY_BIT] && next_busy;
    end
  end

  // control register; single software trigger falls back to pin trigger
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      converter_control_reg <= adcri_pkg::CTL_RESET;
    end else if (clk_en_i) begin
      if (soft_rst) begin
        converter_control_reg <= adcri_pkg::CTL_RESET;
      end else if (wr_ok && hit(bus_req_i.addr, adcri_pkg::OFF_CONTROL)) begin
        converter_control_reg <= bus_req_i.wdata[15:0];
      end else if (conv_done && trig_sel == adcri_pkg::ADCRI_TRIG_SINGLE) begin
        converter_control_reg[adcri_pkg::CTL_TYPE_LSB +: 3] <= 3'h0;
      end
    end
  end

  // channel and gain configuration
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || (clk_en_i && soft_rst)) begin
      positive_channel_select <= adcri_pkg::CHAN_RESET;
      negative_channel_select <= adcri_pkg::CHAN_RESET;
      amplifier_gain_setting  <= adcri_pkg::GAIN_RESET;
    end else if (wr_ok) begin
      if (hit(bus_req_i.addr, adcri_pkg::OFF_POS_SEL)) begin
        positive_channel_select <= bus_req_i.wdata[4:0];
      end
      if (hit(bus_req_i.addr, adcri_pkg::OFF_NEG_SEL)) begin
        negative_channel_select <= bus_req_i.wdata[4:0];
      end
      if (hit(bus_req_i.addr, adcri_pkg::OFF_GAIN)) begin
        amplifier_gain_setting <= bus_req_i.wdata[4:0];
      end
    end
  end

  // port function and mask lie outside the converter and survive a soft reset
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      port0_function_config <= 32'h0000_0000;
      irq_mask              <= 1'b0;
    end else if (wr_ok) begin
      if (hit(bus_req_i.addr, adcri_pkg::OFF_PORT_CFG)) begin
        port0_function_config <= bus_req_i.wdata;
      end
      if (hit(bus_req_i.addr, adcri_pkg::OFF_IRQ_MASK)) begin
        irq_mask <= bus_req_i.wdata[0:0];
      end
    end
  end

  // ready flag: a finishing conversion wins over a clearing read or write-one
  always_comb begin
    next_ready = result_ready_flag;
    if (conv_done && !soft_rst) begin
      next_ready = 1'b1;
    end else if (soft_rst) begin
      next_ready = 1'b0;
    end else if (rd_result) begin
      next_ready = 1'b0;
    end else if (wr_status_clr) begin
      next_ready = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      result_ready_flag <= 1'b0;
    end else if (clk_en_i) begin
      result_ready_flag <= next_ready;
    end
  end

  // the code word has no handshake with the analog core: it must stand two clocks
  // before the conversion ends
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      conversion_result <= 12'h000;
    end else if (clk_en_i) begin
      if (conv_done && !soft_rst) begin
        conversion_result <= code_sync2[11:0];
      end else if (soft_rst) begin
        conversion_result <= 12'h000;
      end
    end
  end

  // interrupt follows the next flag value through the mask, so it falls on the
  // clearing edge; a mask write takes effect one clock later
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_o <= irq_mask[0] && next_ready;
    end
  end

  // result is sign extended; single-ended data treated the same way
  logic [31:0] result_word;
  assign result_word = {{4{conversion_result[11]}}, conversion_result, 16'h0000};

  // read data, one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      rdata_o <= 32'h0000_0000;
      if (bus_req_i.rd) begin
        unique case (bus_req_i.addr)
          adcri_pkg::OFF_CONTROL:  rdata_o <= {16'h0000, converter_control_reg};
          adcri_pkg::OFF_POS_SEL:  rdata_o <= {27'h0, positive_channel_select};
          adcri_pkg::OFF_NEG_SEL:  rdata_o <= {27'h0, negative_channel_select};
          adcri_pkg::OFF_STATUS:   rdata_o <= {31'h0, result_ready_flag};
          adcri_pkg::OFF_RESULT:   rdata_o <= result_word;
          adcri_pkg::OFF_GAIN:     rdata_o <= {27'h0, amplifier_gain_setting};
          adcri_pkg::OFF_IRQ_MASK: rdata_o <= {31'h0, irq_mask};
          adcri_pkg::OFF_PORT_CFG: rdata_o <= port0_function_config;
          default:                 rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // request to the analog core, registered
  // sample is a one-clock pulse; channel, mode and gain follow the registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      conv_req_o <= '0;
    end else if (clk_en_i) begin
      conv_req_o.pos_chan <= positive_channel_select;
      conv_req_o.neg_chan <= negative_channel_select;
      conv_req_o.mode     <= converter_control_reg[adcri_pkg::CTL_MODE_LSB +: 2];
      conv_req_o.gain     <= amplifier_gain_setting;
      conv_req_o.sample   <= start;
    end
  end

endmodule

// ### inc/adcri_pkg.sv
// package of register map, field layout and constants for the converter register interface
package adcri_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RES_W  = 12;

  // register byte addresses
  localparam logic [7:0] OFF_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_POS_SEL   = 8'h04;
  localparam logic [7:0] OFF_NEG_SEL   = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0c;
  localparam logic [7:0] OFF_RESULT    = 8'h10;
  localparam logic [7:0] OFF_SOFT_RST  = 8'h14;
  localparam logic [7:0] OFF_GAIN      = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h1c;
  localparam logic [7:0] OFF_PORT_CFG  = 8'h20;

  // control register fields
  localparam int unsigned CTL_W        = 16;
  localparam int unsigned CTL_TYPE_LSB = 0;
  localparam int unsigned CTL_MODE_LSB = 3;
  localparam int unsigned CTL_PWR_BIT  = 5;
  localparam int unsigned CTL_EN_BIT   = 7;
  localparam int unsigned CTL_ACQ_LSB  = 8;
  localparam int unsigned CTL_DIV_LSB  = 11;
  localparam logic [15:0] CTL_RESET    = 16'h0a00;

  localparam int unsigned CHAN_W       = 5;
  localparam logic [4:0]  CHAN_RESET   = 5'h00;
  localparam logic [4:0]  CHAN_TEMP    = 5'h0d;
  localparam int unsigned GAIN_W       = 5;
  localparam logic [4:0]  GAIN_RESET   = 5'h00;
  localparam int unsigned READY_BIT    = 0;
  localparam int unsigned RESULT_LSB   = 16;
  localparam int unsigned PORT_BUSY_BIT = 2;

  // conversion cost: fixed clocks plus acquisition, all in converter clocks
  localparam logic [7:0] EXTRA_CLOCKS  = 8'h13;
  localparam logic [2:0] TEMP_ACQ_CODE = 3'h3;
  localparam logic [2:0] TEMP_DIV_CODE = 3'h5;

  typedef enum logic [2:0] {
    ADCRI_TRIG_PIN    = 3'h0,
    ADCRI_TRIG_TIMER1 = 3'h1,
    ADCRI_TRIG_TIMER0 = 3'h2,
    ADCRI_TRIG_SINGLE = 3'h3,
    ADCRI_TRIG_CONT   = 3'h4,
    ADCRI_TRIG_LOGIC  = 3'h5
  } adcri_trig_t;

  typedef enum logic [1:0] {
    ADCRI_MODE_SINGLE = 2'h0,
    ADCRI_MODE_DIFF   = 2'h1,
    ADCRI_MODE_PSEUDO = 2'h2
  } adcri_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic       wr;
    logic       rd;
  } adcri_bus_req_t;

  typedef struct packed {
    logic [4:0] pos_chan;
    logic [4:0] neg_chan;
    logic [1:0] mode;
    logic [4:0] gain;
    logic       sample;
  } adcri_conv_req_t;
endpackage

// ### tb/adcri_top_asserts.sv
// port-level checker of the converter register interface
module adcri_chk #(
  parameter int unsigned RES_WIDTH = adcri_pkg::RES_W
) (
  input wire logic                       ref_clk_i,
  input wire logic                       reset_i,
  input wire logic                       clk_en_i,
  input wire adcri_pkg::adcri_bus_req_t  bus_req_i,
  input wire logic [31:0]                rdata_o,
  input wire logic                       conv_pin_i,
  input wire logic                       timer0_i,
  input wire logic                       timer1_i,
  input wire logic                       logic_trig_i,
  input wire logic [RES_WIDTH-1:0]       analog_code_i,
  input wire adcri_pkg::adcri_conv_req_t conv_req_o,
  input wire logic                       busy_o,
  input wire logic                       port0_bit_two_o,
  input wire logic                       irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  property p_rdata_idle;
    $past(clk_en_i) && !$past(bus_req_i.rd) |-> rdata_o == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
  property p_status_bits;
    bus_req_i.rd && clk_en_i && bus_req_i.addr == adcri_pkg::OFF_STATUS |=> rdata_o[31:1] == 31'h0;
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status has extra bits");
  property p_result_fmt;
    bus_req_i.rd && clk_en_i && bus_req_i.addr == adcri_pkg::OFF_RESULT
      |=> rdata_o[15:0] == 16'h0 && rdata_o[31:28] == {4{rdata_o[27]}};
  endproperty
  a_result_fmt: assert property (p_result_fmt) else $error("result word badly placed");
  // a flag set in the read cycle wins, so reads near a conversion end are excluded
  sequence s_result_read;
    bus_req_i.rd && clk_en_i && bus_req_i.addr == adcri_pkg::OFF_RESULT &&
      !busy_o && !$past(busy_o);
  endsequence
  property p_read_clears;
    s_result_read ##1 (clk_en_i && !busy_o) ##1 clk_en_i |-> !irq_o;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("irq kept after result read");
  property p_port_busy;
    port0_bit_two_o |-> busy_o || $past(busy_o);
  endproperty
  a_port_busy: assert property (p_port_busy) else $error("port bit high without busy");
  property p_sample_pulse;
    conv_req_o.sample && clk_en_i |=> !conv_req_o.sample;
  endproperty
  a_sample_pulse: assert property (p_sample_pulse) else $error("sample longer than one cycle");
  property p_busy_start;
    $rose(busy_o) |-> ##[0:1] conv_req_o.sample;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy without a sample");
  property p_busy_min;
    $rose(busy_o) |-> busy_o[*8];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy shorter than a conversion");
  property p_irq_fall;
    $fell(irq_o) |-> $past(bus_req_i.rd || bus_req_i.wr) || $past(bus_req_i.rd || bus_req_i.wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without an access");

  c_busy: cover property ($rose(busy_o));
  c_irq: cover property ($rose(irq_o));
  c_port: cover property (port0_bit_two_o);
endmodule

bind adcri_top adcri_chk #(.RES_WIDTH(RES_WIDTH)) adcri_chk_i (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .bus_req_i(bus_req_i),
  .rdata_o(rdata_o), .conv_pin_i(conv_pin_i), .timer0_i(timer0_i), .timer1_i(timer1_i),
  .logic_trig_i(logic_trig_i), .analog_code_i(analog_code_i), .conv_req_o(conv_req_o),
  .busy_o(busy_o), .port0_bit_two_o(port0_bit_two_o), .irq_o(irq_o)
);

// ### tb/tb.sv
// self-checking testbench of the converter register interface
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       ref_clk_i = 1'b0;
  logic                       reset_i   = 1'b1;
  logic                       clk_en_i  = 1'b1;
  logic [3:0]                 trg       = 4'h0;
  logic [11:0]                code      = 12'h8a5;
  adcri_pkg::adcri_bus_req_t  req       = '0;
  adcri_pkg::adcri_conv_req_t conv_req_o;
  logic [31:0]                rdata_o;
  logic [31:0]                rv;
  logic                       busy_o;
  logic                       port0_bit_two_o;
  logic                       irq_o;
  logic                       pseen;
  logic [2:0]                 tt [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
  logic [3:0]                 tbit [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  int                         num_errors = 0;
  int                         num_checks = 0;
  int                         cyc = 0;
  int                         len;

  always #4 ref_clk_i = ~ref_clk_i;

  adcri_top adcri_top_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .bus_req_i(req),
    .rdata_o(rdata_o), .conv_pin_i(trg[0]), .timer1_i(trg[1]), .timer0_i(trg[2]),
    .logic_trig_i(trg[3]), .analog_code_i(code), .conv_req_o(conv_req_o), .busy_o(busy_o),
    .port0_bit_two_o(port0_bit_two_o), .irq_o(irq_o)
  );

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    req <= '0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    req <= '0;
    #1 rv = rdata_o;
    chk(rv, e);
  endtask

  // counts busy cycles; triggers are dropped once busy shows so a held pin cannot restart
  task automatic conv();
    int n;
    n = 0;
    while (!busy_o && n < 4000) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    pseen = port0_bit_two_o;
    len = 0;
    while (busy_o && len < 4000) begin
      @(posedge ref_clk_i);
      trg <= 4'h0;
      #1 len++;
      pseen |= port0_bit_two_o;
    end
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 10000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    int k;
    repeat (6) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rc(8'h00, 32'h0a00);
    rc(8'h04, 32'h0);
    rc(8'h08, 32'h0);
    rc(8'h0c, 32'h0);
    rc(8'h10, 32'h0);
    rc(8'h18, 32'h0);
    wr(8'h3c, 32'hffff_ffff);
    rc(8'h3c, 32'h0);
    $display("test defaults done");
    for (int m = 0; m < 3; m++) begin
      wr(8'h00, 32'h0a00 | 32'(m << 3));
      rc(8'h00, 32'h0a00 | 32'(m << 3));
    end
    wr(8'h08, 32'h0c);
    rc(8'h08, 32'h0c);
    wr(8'h18, 32'h1f);
    rc(8'h18, 32'h1f);
    wr(8'h04, 32'h0d);
    rc(8'h04, 32'h0d);
    chk(32'(conv_req_o), 32'({5'h0d, 5'h0c, 2'h2, 5'h1f, 1'b0}));
    $display("test registers done");
    wr(8'h1c, 32'h1);
    wr(8'h20, 32'h4);
    wr(8'h00, 32'h0aa3);
    conv();
    chk(32'(len), 32'd1120);
    chk(32'(pseen), 32'h1);
    rc(8'h0c, 32'h1);
    chk(32'(irq_o), 32'h1);
    rc(8'h00, 32'h0aa0);
    rc(8'h10, 32'hf8a5_0000);
    rc(8'h0c, 32'h0);
    chk(32'(irq_o), 32'h0);
    $display("test temperature conversion done");
    wr(8'h04, 32'h2);
    wr(8'h20, 32'h0);
    code <= 12'h3c4;
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'h0aa0 | 32'(tt[i]));
      trg <= tbit[i];
      conv();
      chk(32'(len), 32'd54);
      chk(32'(pseen), 32'h0);
      rc(8'h10, 32'h03c4_0000);
    end
    wr(8'h00, 32'h0aa4);
    conv();
    chk(32'(len), 32'd54);
    conv();
    chk(32'(len), 32'd54);
    wr(8'h00, 32'h0aa0);
    k = 0;
    for (int q = 0; q < 100 && k < 3; q++) begin
      @(posedge ref_clk_i);
      #1 k = busy_o ? 0 : k + 1;
    end
    rc(8'h10, 32'h03c4_0000);
    $display("test triggers done");
    wr(8'h1c, 32'h0);
    wr(8'h00, 32'h0aa3);
    conv();
    rc(8'h0c, 32'h1);
    chk(32'(irq_o), 32'h0);
    wr(8'h1c, 32'h1);
    rc(8'h0c, 32'h1);
    chk(32'(irq_o), 32'h1);
    wr(8'h0c, 32'h1);
    rc(8'h0c, 32'h0);
    chk(32'(irq_o), 32'h0);
    $display("test interrupt mask done");
    wr(8'h00, 32'h0aa3);
    conv();
    wr(8'h18, 32'h1f);
    wr(8'h04, 32'h3);
    rc(8'h0c, 32'h1);
    rc(8'h14, 32'h0);
    rc(8'h00, 32'h0a00);
    rc(8'h04, 32'h0);
    rc(8'h18, 32'h0);
    rc(8'h0c, 32'h0);
    rc(8'h10, 32'h0);
    rc(8'h1c, 32'h1);
    chk(32'(irq_o), 32'h0);
    $display("test soft reset done");
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    wr(8'h18, 32'h05);
    clk_en_i <= 1'b1;
    rc(8'h18, 32'h0);
    wr(8'h18, 32'h05);
    rc(8'h18, 32'h05);
    $display("test clock enable done");
    give_verdict();
  end
endmodule
